/* File: flow_sensor_word_decoder.sv */
// Decoder for temperature and flow-unit descriptor words read from a flow sensor
`timescale 1ns/10ps
`include "flow_unit_defs.svh"
module flow_sensor_word_decoder
   import flow_unit_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input sensor_word_t word_in,
   input wire logic read_unit_cmd,
   output logic signed [15:0] temp_raw,
   output logic signed [15:0] temp_c,
   output logic temp_valid,
   output flow_unit_t unit,
   output logic unit_is_slm,
   output logic unit_valid,
   output logic unit_unsupported,
   output logic [15:0] unit_word,
   output logic unit_word_valid
);

   // ==========================================================
   // State registers
   decoder_state_t st; // Registered state
   decoder_state_t next_st; // Value for the next edge
   logic temp_take; // Temperature word this cycle
   logic unit_take; // Descriptor word this cycle
   logic match_prefix; // Prefix code recognised
   logic match_tbase; // Time base code recognised
   logic match_base; // Base unit code recognised
   logic all_known; // Every field recognised
   logic signed [16:0] temp_diff; // Raw minus offset, one bit wider
   logic signed [16:0] temp_quot; // Whole degrees before narrowing

   assign temp_take = word_in.valid && (word_in.kind == WORD_TEMP);
   assign unit_take = word_in.valid && (word_in.kind == WORD_UNIT);

   // ==========================================================
   // Field checkers, one per constituent
   field_match #(.W(4), .CODE(`PREFIX_ONE)) u_prefix (
      .field(word_in.data[`PREFIX_HI:`PREFIX_LO]),
      .match(match_prefix)
   );
   field_match #(.W(4), .CODE(`TBASE_PER_MIN)) u_tbase (
      .field(word_in.data[`TBASE_HI:`TBASE_LO]),
      .match(match_tbase)
   );
   field_match #(.W(5), .CODE(`BASE_STD_LITRE)) u_base (
      .field(word_in.data[`BASE_HI:`BASE_LO]),
      .match(match_base)
   );

   // Upper three bits take no part in the decision
   assign all_known = match_prefix && match_tbase && match_base;

   // ==========================================================
   // Next-state logic
   // Temperature scaling sits here too, so the state has one combinational filler
   always_comb begin
      next_st = st;
      // Sign extended first, so a negative reading never wraps
      // Constant divisor, so no multi-cycle divider is needed
      temp_diff = $signed({word_in.data[15], word_in.data}) - $signed(`TEMP_OFFSET);
      temp_quot = temp_diff / $signed(`TEMP_SCALE);
      // Pulses default low
      next_st.temp_valid = 1'b0;
      next_st.unit_valid = 1'b0;
      next_st.rd_valid = 1'b0;
      // Temperature word
      if (temp_take) begin
         next_st.temp_raw = $signed(word_in.data);
         next_st.temp_c = temp_quot[15:0];
         next_st.temp_valid = 1'b1;
      end
      // Descriptor word
      if (unit_take) begin
         if (all_known) begin
            next_st.unit.prefix = word_in.data[`PREFIX_HI:`PREFIX_LO];
            next_st.unit.time_base = word_in.data[`TBASE_HI:`TBASE_LO];
            next_st.unit.base = word_in.data[`BASE_HI:`BASE_LO];
            // Upper bits stored as zero, they carry no unit meaning
            next_st.desc = {3'h0, word_in.data[`UNIT_INFO_BITS-1:0]};
            next_st.is_slm = ({3'h0, word_in.data[`UNIT_INFO_BITS-1:0]}
                              == `DESC_SLM);
            next_st.unit_valid = 1'b1;
            next_st.unsupported = 1'b0;
         end else begin
            // Flag only; previous decode stays visible
            next_st.unsupported = 1'b1;
         end
      end
      // Read command returns the descriptor held before this edge
      if (read_unit_cmd) begin
         next_st.rd_word = st.desc;
         next_st.rd_valid = 1'b1;
      end
   end

   // ==========================================================
   // State register with synchronous reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st.temp_raw <= `TEMP_RESET;
         st.temp_c <= `TEMP_RESET;
         st.temp_valid <= 1'b0;
         // Powers up describing standard litres per minute
         st.unit.prefix <= `PREFIX_ONE;
         st.unit.time_base <= `TBASE_PER_MIN;
         st.unit.base <= `BASE_STD_LITRE;
         st.is_slm <= 1'b1;
         st.unit_valid <= 1'b0;
         st.unsupported <= 1'b0;
         st.desc <= `DESC_RESET;
         st.rd_word <= 16'h0000;
         st.rd_valid <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs, all from flip-flops
   assign temp_raw = st.temp_raw;
   assign temp_c = st.temp_c;
   assign temp_valid = st.temp_valid;
   assign unit = st.unit;
   assign unit_is_slm = st.is_slm;
   assign unit_valid = st.unit_valid;
   assign unit_unsupported = st.unsupported;
   assign unit_word = st.rd_word;
   assign unit_word_valid = st.rd_valid;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Accepted descriptor word
   sequence s_unit_good;
      unit_take && all_known;
   endsequence

   // Rejected descriptor word
   sequence s_unit_bad;
      unit_take && !all_known;
   endsequence

   a_temp_signed: assert property (
      temp_take |=> temp_valid && (temp_raw == $signed($past(word_in.data)))
         && ((temp_raw < 0) == $past(word_in.data[15])))
      else $error("temperature word not held as signed value");

   a_upper_ignored: assert property (
      s_unit_good |=> unit_valid && (st.desc[15:13] == 3'h0)
         && (st.desc[12:0] == $past(word_in.data[12:0])))
      else $error("descriptor upper bits not cleared");

   a_prefix_field: assert property (
      s_unit_good |=> unit.prefix == $past(word_in.data[3:0]))
      else $error("prefix not taken from bits 3..0");

   a_tbase_field: assert property (
      s_unit_good |=> unit.time_base == $past(word_in.data[7:4]))
      else $error("time base not taken from bits 7..4");

   a_base_field: assert property (
      s_unit_good |=> unit.base == $past(word_in.data[12:8]))
      else $error("base unit not taken from bits 12..8");

   a_codes_known: assert property (
      unit_valid |-> (unit.prefix == 4'h8) && (unit.time_base == 4'h4)
         && (unit.base == 5'h01) && !unit_unsupported)
      else $error("decoded unit outside recognised codes");

   a_slm_decode: assert property (
      (unit_take && (word_in.data == 16'h0148)) |=> unit_valid && unit_is_slm)
      else $error("0x0148 not decoded as slm");

   a_read_cmd: assert property (
      read_unit_cmd |=> unit_word_valid && (unit_word == $past(st.desc))
         ##1 ($past(read_unit_cmd) == unit_word_valid))
      else $error("read command did not return descriptor");

   a_reject_hold: assert property (
      s_unit_bad |=> unit_unsupported && !unit_valid && $stable(unit)
         && $stable(st.desc))
      else $error("unknown descriptor not flagged or unit changed");

   // Scaled value stays inside the full-range bound and keeps the sign
   a_temp_range: assert property (
      temp_valid |-> (temp_c <= 16'sh00A3) && (temp_c >= -16'sh00A3)
         && ((temp_c >= 16'sh0000) || (temp_raw < 16'sh0000)))
      else $error("scaled temperature out of range or sign lost");

   // Temperature strobe only after a temperature word
   a_temp_pulse: assert property (
      !temp_take |=> !temp_valid)
      else $error("temperature strobe without a temperature word");

   // Descriptor strobe only after an accepted word
   a_unit_pulse: assert property (
      !(unit_take && all_known) |=> !unit_valid)
      else $error("descriptor strobe without an accepted word");

   // Accepted word clears the unsupported flag
   a_flag_clear: assert property (
      s_unit_good |=> unit_valid && !unit_unsupported)
      else $error("unsupported flag not cleared by accepted word");

   // Unit levels hold while no descriptor arrives
   a_unit_hold: assert property (
      !unit_take |=> $stable(unit) && $stable(unit_is_slm) && $stable(unit_unsupported))
      else $error("unit levels changed without a descriptor word");

   // Litre-per-minute level follows the low thirteen bits of the accepted word
   a_slm_level: assert property (
      s_unit_good |=> unit_is_slm == ($past(word_in.data[12:0]) == 13'h0148))
      else $error("slm level does not match accepted descriptor");

endmodule

/* File: flow_unit_defs.svh */
// Field positions, encodings, reset values and scaling constants of the flow word decoder
`ifndef FLOW_UNIT_DEFS_SVH
`define FLOW_UNIT_DEFS_SVH

// ==========================================================
// Descriptor field layout
`define UNIT_INFO_BITS 13
`define PREFIX_HI 3
`define PREFIX_LO 0
`define TBASE_HI 7
`define TBASE_LO 4
`define BASE_HI 12
`define BASE_LO 8

// ==========================================================
// Recognised field encodings
`define PREFIX_ONE 4'h8
`define TBASE_PER_MIN 4'h4
`define BASE_STD_LITRE 5'h01
`define DESC_SLM 16'h0148

// ==========================================================
// Reset values
`define DESC_RESET 16'h0148
`define TEMP_RESET 16'h0000

// ==========================================================
// Temperature conversion: degrees = (raw - offset) / scale
`define TEMP_OFFSET 17'h00000
`define TEMP_SCALE 17'h000C8

`endif

/* File: flow_unit_pkg.sv */
// Types shared by the flow word decoder, the sensor model and the testbench
package flow_unit_pkg;

   // ==========================================================
   // Kind of word delivered by the serial engine
   typedef enum logic [0:0] {
      WORD_TEMP,
      WORD_UNIT
   } word_kind_t;

   // ==========================================================
   // One received data word with its kind
   typedef struct packed {
      logic valid;
      word_kind_t kind;
      logic [15:0] data;
   } sensor_word_t;

   // ==========================================================
   // Decoded flow unit constituents
   typedef struct packed {
      logic [4:0] base;
      logic [3:0] time_base;
      logic [3:0] prefix;
   } flow_unit_t;

   // ==========================================================
   // Whole state of the decoder
   typedef struct packed {
      logic signed [15:0] temp_raw;
      logic signed [15:0] temp_c;
      logic temp_valid;
      flow_unit_t unit;
      logic is_slm;
      logic unit_valid;
      logic unsupported;
      logic [15:0] desc;
      logic [15:0] rd_word;
      logic rd_valid;
   } decoder_state_t;

endpackage

/* File: field_match.sv */
// Compares one descriptor field with its single recognised encoding
`timescale 1ns/10ps
module field_match #(
   parameter int W = 4,
   parameter logic [W-1:0] CODE = '0
) (
   input wire logic [W-1:0] field,
   output logic match
);

   // ==========================================================
   // Plain equality; only one code per field is defined so far
   assign match = (field == CODE);

endmodule

/* File: flow_sensor_model.sv */
// Behavioural model of the flow sensor that delivers data words to the decoder
`timescale 1ns/10ps
module flow_sensor_model
   import flow_unit_pkg::*;
(
   input wire logic clk,
   output sensor_word_t word
);
   // ==========================================================
   // Word source
   // Idle from time zero so the decoder sees no stray word
   initial begin
      word = '{valid: 1'b0, kind: WORD_TEMP, data: 16'h0000};
   end

   // One word per call, launched and withdrawn on falling edges
   task automatic put(input word_kind_t kind, input logic [15:0] data);
      @(negedge clk);
      // Temperature goes out as raw two's complement, descriptor as a 16-bit word
      word = '{valid: 1'b1, kind: kind, data: data};
      @(negedge clk);
      // Withdrawn data shows the inverse, so a stale sample cannot look right
      word = '{valid: 1'b0, kind: kind, data: ~data};
   endtask
endmodule

/* File: tb_top.sv */
// Self-checking testbench of the flow sensor word decoder
`timescale 1ns/10ps
module tb_top
   import flow_unit_pkg::*;
;
   // ==========================================================
   // Clock, reset and design signals
   logic clk = 1'b0; // 50 MHz
   logic rst_n = 1'b0; // Synchronous, active low
   logic read_unit_cmd = 1'b0; // Descriptor read request
   sensor_word_t word_in; // Driven by the sensor model
   logic signed [15:0] temp_raw, temp_c;
   logic temp_valid, unit_is_slm, unit_valid, unit_unsupported, unit_word_valid;
   flow_unit_t unit;
   logic [15:0] unit_word;
   int err_total = 0; // Mismatches
   int n_checks = 0; // Comparisons
   int cycles = 0; // Hang guard
   logic [15:0] bad [3] = '{16'h0149, 16'h0108, 16'h0048}; // One bad field each

   always #10 clk = ~clk;

   flow_sensor_model sensor (.clk(clk), .word(word_in));

   flow_sensor_word_decoder uut (.clk(clk), .rst_n(rst_n), .word_in(word_in),
      .read_unit_cmd(read_unit_cmd), .temp_raw(temp_raw), .temp_c(temp_c),
      .temp_valid(temp_valid), .unit(unit), .unit_is_slm(unit_is_slm),
      .unit_valid(unit_valid), .unit_unsupported(unit_unsupported),
      .unit_word(unit_word), .unit_word_valid(unit_word_valid));

   // ==========================================================
   // Shared helpers
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Read command; the answer is due one cycle later
   task automatic read_desc(input logic [15:0] exp);
      @(negedge clk);
      read_unit_cmd = 1'b1;
      @(negedge clk);
      read_unit_cmd = 1'b0;
      chk("unit_word_valid", {15'h0000, unit_word_valid}, 16'h0001);
      chk("unit_word", unit_word, exp);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   // Minus 200 and both extremes of the signed range; scale 200, offset 0, truncation toward zero
   task automatic t_temp();
      logic [15:0] raw [3] = '{16'hFF38, 16'h7FFF, 16'h8000};
      logic [15:0] deg [3] = '{16'hFFFF, 16'h00A3, 16'hFF5D};
      for (int i = 0; i < 3; i++) begin
         sensor.put(WORD_TEMP, raw[i]);
         chk("temp_valid", {15'h0000, temp_valid}, 16'h0001);
         chk("temp_raw", temp_raw, raw[i]);
         chk("temp_c", temp_c, deg[i]);
      end
      $display("test temp done");
   endtask

   // Upper bits carry nothing; fields land in their positions
   task automatic t_unit_ok();
      sensor.put(WORD_UNIT, 16'hE148);
      chk("unit_valid", {15'h0000, unit_valid}, 16'h0001);
      chk("unit", {3'h0, unit}, 16'h0148);
      chk("unit_is_slm", {15'h0000, unit_is_slm}, 16'h0001);
      read_desc(16'h0148);
      $display("test unit_ok done");
   endtask

   // Each field given a wrong code in turn; old unit must survive
   task automatic t_unit_bad();
      for (int i = 0; i < 3; i++) begin
         sensor.put(WORD_UNIT, bad[i]);
         chk("unsupported", {15'h0000, unit_unsupported}, 16'h0001);
         chk("unit_valid", {15'h0000, unit_valid}, 16'h0000);
         chk("unit", {3'h0, unit}, 16'h0148);
      end
      read_desc(16'h0148);
      sensor.put(WORD_UNIT, 16'h0148);
      chk("unsupported", {15'h0000, unit_unsupported}, 16'h0000);
      $display("test unit_bad done");
   endtask

   // ==========================================================
   // Main sequence and hang guard
   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      chk("unit reset", {3'h0, unit}, 16'h0148);
      chk("temp reset", temp_raw, 16'h0000);
      t_temp();
      t_unit_ok();
      t_unit_bad();
      tally_and_finish();
   end

   // Whole run needs well under a hundred cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 1000) begin
         err_total++;
         tally_and_finish();
      end
   end
endmodule
